// *** design/fpm_port.sv ***
// Processor-side fast memory port: select, cycle sequencing, parity report.
// Assumes all processor inputs are asynchronous and are synchronised here.
//
// How it works
// - At most four matrix modules, 4K small-type or 16K dense-type words.
// - One storage type per controller, fixed by a parameter.
// - Read loads the word into the output latch, no restore write.
// - Read-with-pause reads, then holds memory until the write begins or a parity error is flagged.
// - Word write stores all 16 bits at once, no prior clearing.
// - Byte write stores one byte by address, other byte kept.
// - Only the controller owning the address asserts memory-selected.
// - Fast-path select from processor blocks secondary-bus addressing.
// - Bus start sets request flag; with selection it latches address.
// - Access-type bits come before confirm and decode into four types.
// - Cycle-sync only when access ready and cycle-confirm both hold.
// - Write cycles: sync with bit one latches data and pulses write.
// - Bit one low marks reads and suppresses the write strobe.
// - Reads set the sense latch after sync; data returned on data-in.
// - After confirm, a read finishes without further processor signals.
// - Cycle abort ends the access that bus start began.
// - Parity error flag held until processor acknowledges it.
// - Separate 16-bit write-data and read-data paths.
// - Parity per byte in bits 16 and 17; byte write updates one.
// - Parity checked after each word reaches the output register.
// - Address bit 0 low is word or low byte, high is high byte.
`default_nettype none

module fpm_port #(
  parameter logic       MATRIX_TYPE = fpm_pkg::MT_DENSE,
  parameter int         NUM_MODULES = fpm_pkg::MAX_MODULES,
  parameter int         BASE_WORD   = 0
) (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic [fpm_pkg::ADDR_W-1:0]  cpu_addr,
  input  wire logic [fpm_pkg::DATA_W-1:0]  cpu_data_out,
  output logic      [fpm_pkg::DATA_W-1:0]  cpu_data_in,
  input  wire logic                        fast_path_select,
  input  wire logic                        bus_start,
  input  wire logic                        cycle_confirm,
  input  wire logic                        access_type_bit_one,
  input  wire logic                        access_type_bit_zero,
  input  wire logic                        cycle_abort,
  input  wire logic                        parity_error_ack,
  output logic                             mem_selected,
  output logic                             cycle_sync,
  output logic                             parity_error_flag,
  output logic                             secondary_bus_block
);
  // ****************************************
  // Sizing
  // ****************************************
  localparam int MOD_WORDS = (MATRIX_TYPE == fpm_pkg::MT_DENSE) ?
                             fpm_pkg::DENSE_WORDS : fpm_pkg::SMALL_WORDS;
  localparam int N_MOD     = (NUM_MODULES > fpm_pkg::MAX_MODULES) ?
                             fpm_pkg::MAX_MODULES : NUM_MODULES;
  localparam int CAP_WORDS = N_MOD * MOD_WORDS;
  localparam logic [fpm_pkg::CNT_W-1:0] ACC_LOAD =
                             fpm_pkg::CNT_W'(fpm_pkg::ACCESS_CYC - 1);

  // ****************************************
  // Input synchroniser
  // ****************************************
  logic [fpm_pkg::SYNC_W-1:0] meta_reg;
  logic [fpm_pkg::SYNC_W-1:0] sync_reg;
  logic                       start_prev_reg;

  // Two stages; only the second stage is read by logic
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg       <= '0;
      sync_reg       <= '0;
      start_prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg       <= {cpu_addr, cpu_data_out, fast_path_select, bus_start,
                         cycle_confirm, access_type_bit_one, access_type_bit_zero,
                         cycle_abort, parity_error_ack};
      sync_reg       <= meta_reg;
      start_prev_reg <= sync_reg[5];
    end
  end

  logic [fpm_pkg::ADDR_W-1:0] addr_s;
  logic [fpm_pkg::DATA_W-1:0] data_s;
  logic                       fast_s;
  logic                       start_s;
  logic                       conf_s;
  logic [1:0]                 at_s;
  logic                       abort_s;
  logic                       ack_s;
  logic                       start_rise;

  // Field split of the synchronised bundle
  assign addr_s     = sync_reg[fpm_pkg::SYNC_W-1 -: fpm_pkg::ADDR_W];
  assign data_s     = sync_reg[fpm_pkg::DATA_W+6 : 7];
  assign fast_s     = sync_reg[6];
  assign start_s    = sync_reg[5];
  assign conf_s     = sync_reg[4];
  assign at_s       = sync_reg[3:2];
  assign abort_s    = sync_reg[1];
  assign ack_s      = sync_reg[0];
  assign start_rise = start_s & ~start_prev_reg;

  // ****************************************
  // Address decode and matrix
  // ****************************************
  logic                      hit;
  logic [fpm_pkg::MAD_W-1:0] offset;

  fpm_addr_dec #(
    .BASE_WORD (BASE_WORD),
    .CAP_WORDS (CAP_WORDS),
    .AW        (fpm_pkg::MAD_W)
  ) u_dec (
    .word_addr (addr_s[fpm_pkg::ADDR_W-1:1]),
    .hit       (hit),
    .offset    (offset)
  );

  fpm_mat_if #(.AW(fpm_pkg::MAD_W)) mbus ();

  fpm_matrix #(
    .DEPTH  (CAP_WORDS),
    .AW     (fpm_pkg::MAD_W)
  ) u_mat (
    .clk    (clk),
    .arst_n (arst_n),
    .mat    (mbus)
  );

  // ****************************************
  // Cycle sequencer
  // ****************************************
  fpm_pkg::fpm_state_t       state_reg;
  fpm_pkg::fpm_state_t       state_next;
  logic [fpm_pkg::CNT_W-1:0] cnt_reg;
  logic [fpm_pkg::CNT_W-1:0] cnt_next;
  logic                      processor_request_flag_reg;
  logic                      mem_sel_reg;
  logic [fpm_pkg::MAD_W-1:0] mad_reg;
  logic                      odd_reg;
  logic                      start_ok;
  logic                      in_access;
  logic                      aborting;
  logic                      is_write;

  assign start_ok  = processor_request_flag_reg & mem_sel_reg;
  assign in_access = (state_reg == fpm_pkg::ST_LATCH) ||
                     (state_reg == fpm_pkg::ST_ACCESS) ||
                     (state_reg == fpm_pkg::ST_CONFIRM);
  assign aborting  = in_access & abort_s;
  assign is_write  = at_s[1];

  // Next state; after confirm only a read-with-pause waits on the processor, in ST_PAUSE for the write
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      fpm_pkg::ST_IDLE:
        if (start_ok)
          state_next = fpm_pkg::ST_LATCH;
      fpm_pkg::ST_PAUSE:
        if (parity_error_flag)
          state_next = fpm_pkg::ST_IDLE;
        else if (start_ok && is_write)
          state_next = fpm_pkg::ST_LATCH;
      fpm_pkg::ST_LATCH:
      begin
        state_next = fpm_pkg::ST_ACCESS;
        cnt_next   = ACC_LOAD;
      end
      fpm_pkg::ST_ACCESS:
        if (cnt_reg == '0)
          state_next = fpm_pkg::ST_CONFIRM;
        else
          cnt_next = cnt_reg - 1'b1;
      fpm_pkg::ST_CONFIRM:
        if (conf_s)
          state_next = fpm_pkg::ST_SYNC;
      fpm_pkg::ST_SYNC:
        if (at_s == fpm_pkg::AT_READ_PAUSE)
          state_next = fpm_pkg::ST_PAUSE;
        else
          state_next = fpm_pkg::ST_IDLE;
      default:
        state_next = fpm_pkg::ST_IDLE;
    endcase
    if (aborting)
      state_next = fpm_pkg::ST_IDLE;
  end

  // State, counter, request flag (set wins over clear)
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg   <= fpm_pkg::ST_IDLE;
      cnt_reg     <= '0;
      processor_request_flag_reg    <= 1'b0;
      mem_sel_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      processor_request_flag_reg    <= start_rise | (processor_request_flag_reg & ~aborting &
                     (state_reg != fpm_pkg::ST_LATCH));
      mem_sel_reg <= hit;
    end
  end

  // Memory address register, loaded first in every cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mad_reg <= '0;
      odd_reg <= 1'b0;
    end
    else if (state_reg == fpm_pkg::ST_LATCH)
    begin
      mad_reg <= offset;
      odd_reg <= addr_s[0];
    end
  end

  // ****************************************
  // Write path
  // ****************************************
  logic                       wr_reg;
  logic [fpm_pkg::DATA_W-1:0] din_reg;
  logic [1:0]                 lane_reg;
  logic [1:0]                 lane_sel;
  logic                       wr_strobe;

  assign cycle_sync = (state_reg == fpm_pkg::ST_SYNC);
  assign wr_strobe  = cycle_sync & is_write;
  assign lane_sel   = (at_s == fpm_pkg::AT_WORD_WRITE) ? fpm_pkg::LANE_WORD :
                      odd_reg ? fpm_pkg::LANE_HIGH : fpm_pkg::LANE_LOW;

  // Data latch and write pulse fire together, one cycle after sync
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_reg   <= 1'b0;
      din_reg  <= '0;
      lane_reg <= fpm_pkg::LANE_NONE;
    end
    else
    begin
      wr_reg <= wr_strobe;
      if (wr_strobe)
      begin
        din_reg  <= data_s;
        lane_reg <= lane_sel;
      end
    end
  end

  // Parity is generated per byte; the unwritten lane keeps its own
  assign mbus.addr    = mad_reg;
  assign mbus.write   = wr_reg;
  assign mbus.lane_en = lane_reg;
  assign mbus.wdata   = {fpm_pkg::fpm_par(din_reg[15:8]),
                         fpm_pkg::fpm_par(din_reg[7:0]), din_reg};

  // ****************************************
  // Read path and parity report
  // ****************************************
  logic [fpm_pkg::DATA_W-1:0] dout_reg;
  logic [1:0]                 prd_reg;
  logic                       sense_reg;
  logic                       pef_reg;
  logic                       par_err;
  logic                       rd_end;

  assign rd_end  = cycle_sync & ~is_write;
  assign par_err = (^{dout_reg[7:0], prd_reg[0]}) |
                   (^{dout_reg[15:8], prd_reg[1]});

  // Sense latch at the end of sync; readout needs no restore
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dout_reg  <= '0;
      prd_reg   <= '0;
      sense_reg <= 1'b0;
      pef_reg   <= 1'b0;
    end
    else
    begin
      sense_reg <= rd_end;
      if (rd_end)
      begin
        dout_reg <= mbus.rdata[fpm_pkg::DATA_W-1:0];
        prd_reg  <= mbus.rdata[fpm_pkg::PAR_HI_BIT:fpm_pkg::PAR_LO_BIT];
      end
      pef_reg <= (sense_reg & par_err) | (pef_reg & ~ack_s);
    end
  end

  // Outputs; pause also keeps the secondary bus off the memory
  assign cpu_data_in         = dout_reg;
  assign mem_selected        = mem_sel_reg;
  assign parity_error_flag   = pef_reg;
  assign secondary_bus_block = fast_s | (state_reg == fpm_pkg::ST_PAUSE);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_ready_conf;
    (state_reg == fpm_pkg::ST_CONFIRM) && conf_s && !abort_s;
  endsequence

  sequence s_read_sync;
    cycle_sync && !at_s[1];
  endsequence

  a_sync_needs_conf: assert property (
    $rose(cycle_sync) |-> $past(conf_s) && $past(state_reg == fpm_pkg::ST_CONFIRM))
    else $error("sync without ready and confirm");
  a_sync_follows: assert property (s_ready_conf |=> cycle_sync ##1 !cycle_sync)
    else $error("sync not one cycle after confirm");
  a_write_pulse: assert property (
    cycle_sync && at_s[1] |=> wr_reg && din_reg == $past(data_s))
    else $error("write pulse or data latch missing");
  a_read_no_write: assert property (s_read_sync |=> !wr_reg ##1 !wr_reg)
    else $error("write during read cycle");
  a_sense_load: assert property (
    s_read_sync |=> sense_reg && cpu_data_in == $past(mbus.rdata[15:0]))
    else $error("sense latch not loaded");
  a_abort_ends: assert property (aborting |=> state_reg == fpm_pkg::ST_IDLE)
    else $error("abort did not end cycle");
  a_par_report: assert property (sense_reg && par_err |=> parity_error_flag)
    else $error("parity error not flagged");
  a_par_hold: assert property (
    parity_error_flag && !ack_s && !(sense_reg && par_err) |=> parity_error_flag)
    else $error("parity flag dropped without ack");
  a_mad_latch: assert property (
    state_reg == fpm_pkg::ST_LATCH |=> mbus.addr == $past(offset))
    else $error("address not latched");
  a_access_time: assert property (
    state_reg == fpm_pkg::ST_LATCH && !abort_s ##1 !abort_s [*5]
    |-> state_reg == fpm_pkg::ST_ACCESS)
    else $error("access ended early");
  a_pause_hold: assert property (
    cycle_sync && at_s == fpm_pkg::AT_READ_PAUSE |=>
    secondary_bus_block && state_reg == fpm_pkg::ST_PAUSE)
    else $error("pause did not hold memory");
  a_byte_lane: assert property (
    cycle_sync && at_s == fpm_pkg::AT_BYTE_WRITE |=>
    mbus.lane_en == (odd_reg ? fpm_pkg::LANE_HIGH : fpm_pkg::LANE_LOW))
    else $error("wrong byte lane");
  a_select_block: assert property (fast_s |-> secondary_bus_block)
    else $error("secondary bus not blocked");
endmodule : fpm_port

`default_nettype wire

// *** shared/fpm_pkg.sv ***
// Constants, types and helpers for the fast processor memory port.
// Assumes a single 20 MHz clock domain shared by all design modules.
`default_nettype none

package fpm_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS     = 50;
  localparam int ACCESS_NS  = 250;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 3;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W      = 18;
  localparam int WADDR_W     = 17;
  localparam int DATA_W      = 16;
  localparam int WORD_W      = 18;
  localparam int PAR_LO_BIT  = 16;
  localparam int PAR_HI_BIT  = 17;
  localparam int MAD_W       = 14;
  localparam int SMALL_WORDS = 1024;
  localparam int DENSE_WORDS = 4096;
  localparam int MAX_MODULES = 4;
  localparam int SYNC_W      = ADDR_W + DATA_W + 7;

  // Matrix storage types, one per controller
  localparam logic MT_SMALL = 1'b0;
  localparam logic MT_DENSE = 1'b1;

  // Access type codes, bit one first
  localparam logic [1:0] AT_READ       = 2'h0;
  localparam logic [1:0] AT_READ_PAUSE = 2'h1;
  localparam logic [1:0] AT_WORD_WRITE = 2'h2;
  localparam logic [1:0] AT_BYTE_WRITE = 2'h3;

  // Byte lane enables
  localparam logic [1:0] LANE_NONE = 2'h0;
  localparam logic [1:0] LANE_LOW  = 2'h1;
  localparam logic [1:0] LANE_HIGH = 2'h2;
  localparam logic [1:0] LANE_WORD = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_LATCH   = 6'h02,
    ST_ACCESS  = 6'h04,
    ST_CONFIRM = 6'h08,
    ST_SYNC    = 6'h10,
    ST_PAUSE   = 6'h20
  } fpm_state_t;

  // Even parity bit for one byte
  function automatic logic fpm_par(input logic [7:0] b);
    return ^b;
  endfunction : fpm_par

endpackage : fpm_pkg

`default_nettype wire

// *** shared/fpm_mat_if.sv ***
// Word path between the port controller and its matrix storage.
// Assumes both ends run on the controller clock.
`default_nettype none

interface fpm_mat_if #(
  parameter int AW = fpm_pkg::MAD_W
);
  logic [AW-1:0]              addr;
  logic [fpm_pkg::WORD_W-1:0] wdata;
  logic [fpm_pkg::WORD_W-1:0] rdata;
  logic [1:0]                 lane_en;
  logic                       write;

  modport ctrl (output addr, output wdata, output lane_en, output write, input rdata);
  modport mat  (input addr, input wdata, input lane_en, input write, output rdata);
endinterface : fpm_mat_if

`default_nettype wire

// *** design/fpm_addr_dec.sv ***
// Range decoder: tells whether a word address falls in this controller.
// Assumes the word address is already synchronised.
`default_nettype none

module fpm_addr_dec #(
  parameter int BASE_WORD = 0,
  parameter int CAP_WORDS = 4096,
  parameter int AW        = fpm_pkg::MAD_W
) (
  input  wire logic [fpm_pkg::WADDR_W-1:0] word_addr,
  output logic                             hit,
  output logic [AW-1:0]                    offset
);
  localparam logic [fpm_pkg::WADDR_W:0] BASE_X = (fpm_pkg::WADDR_W+1)'(BASE_WORD);
  localparam logic [fpm_pkg::WADDR_W:0] END_X  = (fpm_pkg::WADDR_W+1)'(BASE_WORD + CAP_WORDS);

  logic [fpm_pkg::WADDR_W:0] addr_x;
  logic [fpm_pkg::WADDR_W:0] rel_x;

  // Window compare and rebase into the matrix
  assign addr_x = {1'b0, word_addr};
  assign rel_x  = addr_x - BASE_X;
  assign hit    = (addr_x >= BASE_X) && (addr_x < END_X);
  assign offset = rel_x[AW-1:0];
endmodule : fpm_addr_dec

`default_nettype wire

// *** design/fpm_matrix.sv ***
// Matrix storage: up to four modules of one type, 16 data plus 2 parity bits.
// Assumes the controller only issues in-range addresses.
`default_nettype none

module fpm_matrix #(
  parameter int DEPTH = 4096,
  parameter int AW    = fpm_pkg::MAD_W
) (
  input  wire logic clk,
  input  wire logic arst_n,
  fpm_mat_if.mat    mat
);
  logic [fpm_pkg::WORD_W-1:0] mem [DEPTH];
  logic [fpm_pkg::WORD_W-1:0] rdata_reg;
  logic                       in_range;

  assign in_range  = 32'(mat.addr) < DEPTH;
  assign mat.rdata = rdata_reg;

  // Lane writes carry their own parity bit; the other lane is untouched
  always_ff @(posedge clk)
  begin
    if (mat.write && in_range && mat.lane_en[0])
    begin
      mem[mat.addr][7:0]                    <= mat.wdata[7:0];
      mem[mat.addr][fpm_pkg::PAR_LO_BIT]    <= mat.wdata[fpm_pkg::PAR_LO_BIT];
    end
    if (mat.write && in_range && mat.lane_en[1])
    begin
      mem[mat.addr][15:8]                   <= mat.wdata[15:8];
      mem[mat.addr][fpm_pkg::PAR_HI_BIT]    <= mat.wdata[fpm_pkg::PAR_HI_BIT];
    end
  end

  // Non-destructive registered readout
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_reg <= '0;
    else if (in_range)
      rdata_reg <= mem[mat.addr];
  end
endmodule : fpm_matrix

`default_nettype wire

// *** dv/fpm_cpu_model.sv ***
// Processor model for the fast memory path: one task runs a whole transfer.
// Assumes clk comes from the bench and results return through task outputs and perr_seen.
`default_nettype none

module fpm_cpu_model (
  input  wire logic        clk,
  input  wire logic        mem_selected,
  input  wire logic        cycle_sync,
  input  wire logic        parity_error_flag,
  input  wire logic [15:0] cpu_data_in,
  output logic      [17:0] cpu_addr,
  output logic      [15:0] cpu_data_out,
  output logic             fast_path_select,
  output logic             bus_start,
  output logic             cycle_confirm,
  output logic             access_type_bit_one,
  output logic             access_type_bit_zero,
  output logic             cycle_abort,
  output logic             parity_error_ack
);
  timeunit 1ns;
  timeprecision 1ns;

  // Flag as seen when confirm drops; the ack clears the pin soon after
  logic perr_seen;

  // Quiet bus at time zero
  initial
  begin
    {cpu_addr, cpu_data_out} = '0;
    {fast_path_select, bus_start, cycle_confirm, cycle_abort} = '0;
    {access_type_bit_one, access_type_bit_zero, parity_error_ack} = '0;
    perr_seen = 1'b0;
  end

  // Select alone, with no transfer behind it
  task automatic select_only(input logic v);
    @(posedge clk);
    fast_path_select <= v;
  endtask : select_only

  // ****
  // Transfer
  // ****
  // cyc is the wait for sync in cycles, -1 when none came; cf is when confirm rises
  task automatic run(input logic [17:0] a, input logic [1:0] t, input logic [15:0] d,
                     input int cf, input bit ab, output int cyc, output logic [15:0] rd);
    int n;
    cyc = -1;
    rd = cpu_data_in;
    @(posedge clk);
    cpu_addr <= a;
    {access_type_bit_one, access_type_bit_zero} <= t;
    cpu_data_out <= d;
    // Selection answers three edges after the address, so skip a stale one
    repeat (4) @(posedge clk);
    for (n = 0; n < 8 && mem_selected !== 1'b1; n++)
      @(posedge clk);
    if (mem_selected !== 1'b1)
      return;
    fast_path_select <= 1'b1;
    bus_start <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge clk);
      if (cycle_sync === 1'b1)
        break;
      if (n == cf && ab)
        cycle_abort <= 1'b1;
      else if (n == cf)
        cycle_confirm <= 1'b1;
    end
    if (n < 60)
      cyc = n;
    // Flag lands two edges after sync, so look one edge later still
    repeat (3) @(posedge clk);
    rd = cpu_data_in;
    {cycle_confirm, cycle_abort, bus_start, fast_path_select} <= '0;
    perr_seen = parity_error_flag;
    parity_error_ack <= parity_error_flag;
    cpu_data_out <= ~d;
    repeat (6) @(posedge clk);
    parity_error_ack <= 1'b0;
  endtask : run

endmodule : fpm_cpu_model

`default_nettype wire

// *** dv/tb_fast_processor_memory_port.sv ***
// Self-checking bench for fpm_port, driven through the processor model.
// Assumes the package, design files and fpm_cpu_model are compiled first.
`default_nettype none

module tb_fast_processor_memory_port;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [17:0] cpu_addr;
  logic [15:0] cpu_data_out;
  logic [15:0] cpu_data_in;
  logic        fps, bstart, confirm, bit_one, bit_zero, abort, ack;
  logic        mem_selected, cycle_sync, perr, sec_block;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          c;
  logic [15:0] rd;

  always #25 clk = ~clk;

  fpm_port fpm_port_inst (
    .clk(clk), .arst_n(arst_n), .cpu_addr(cpu_addr), .cpu_data_out(cpu_data_out),
    .cpu_data_in(cpu_data_in), .fast_path_select(fps), .bus_start(bstart),
    .cycle_confirm(confirm), .access_type_bit_one(bit_one),
    .access_type_bit_zero(bit_zero), .cycle_abort(abort), .parity_error_ack(ack),
    .mem_selected(mem_selected), .cycle_sync(cycle_sync),
    .parity_error_flag(perr), .secondary_bus_block(sec_block)
  );

  fpm_cpu_model fpm_cpu_model_inst (
    .clk(clk), .mem_selected(mem_selected), .cycle_sync(cycle_sync),
    .parity_error_flag(perr), .cpu_data_in(cpu_data_in), .cpu_addr(cpu_addr),
    .cpu_data_out(cpu_data_out), .fast_path_select(fps), .bus_start(bstart),
    .cycle_confirm(confirm), .access_type_bit_one(bit_one),
    .access_type_bit_zero(bit_zero), .cycle_abort(abort), .parity_error_ack(ack)
  );

  // ****
  // Checking and closing
  // ****
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Whole run needs well under a thousand cycles; a hang is cut short here
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      end_sim;
    end
  end

  // Plain transfer with a prompt confirm
  task automatic xfer(input logic [17:0] a, input logic [1:0] t, input logic [15:0] d);
    fpm_cpu_model_inst.run(a, t, d, 2, 1'b0, c, rd);
  endtask : xfer

  // ****
  // Scenarios
  // ****
  task automatic t_word;
    xfer(18'h00100, fpm_pkg::AT_WORD_WRITE, 16'ha5c3);
    chk_bit(c >= 0, 1'b1);
    xfer(18'h00100, fpm_pkg::AT_READ, 16'h0000);
    chk_data(rd, 16'ha5c3);
    chk_bit(fpm_cpu_model_inst.perr_seen, 1'b0);
  endtask : t_word

  // Late confirm must hold sync back
  task automatic t_slow;
    fpm_cpu_model_inst.run(18'h00102, fpm_pkg::AT_WORD_WRITE, 16'h3c5a, 30, 1'b0, c, rd);
    chk_bit(c > 30, 1'b1);
    xfer(18'h00102, fpm_pkg::AT_READ, 16'h0000);
    chk_data(rd, 16'h3c5a);
  endtask : t_slow

  // Foreign byte in the other lane proves only one byte is stored
  task automatic t_byte;
    xfer(18'h00200, fpm_pkg::AT_WORD_WRITE, 16'h1234);
    xfer(18'h00201, fpm_pkg::AT_BYTE_WRITE, 16'hab77);
    xfer(18'h00200, fpm_pkg::AT_READ, 16'h0000);
    chk_data(rd, 16'hab34);
    xfer(18'h00200, fpm_pkg::AT_BYTE_WRITE, 16'h99cd);
    xfer(18'h00200, fpm_pkg::AT_READ, 16'h0000);
    chk_data(rd, 16'habcd);
    chk_bit(fpm_cpu_model_inst.perr_seen, 1'b0);
  endtask : t_byte

  task automatic t_pause;
    xfer(18'h00300, fpm_pkg::AT_WORD_WRITE, 16'h0f0f);
    xfer(18'h00300, fpm_pkg::AT_READ_PAUSE, 16'h0000);
    chk_data(rd, 16'h0f0f);
    chk_bit(sec_block, 1'b1);
    xfer(18'h00300, fpm_pkg::AT_WORD_WRITE, 16'h5555);
    chk_bit(sec_block, 1'b0);
    xfer(18'h00300, fpm_pkg::AT_READ, 16'h0000);
    chk_data(rd, 16'h5555);
  endtask : t_pause

  // Aborted write must leave the old word and free the port
  task automatic t_abort;
    xfer(18'h00400, fpm_pkg::AT_WORD_WRITE, 16'h1111);
    fpm_cpu_model_inst.run(18'h00400, fpm_pkg::AT_WORD_WRITE, 16'h2222, 2, 1'b1, c, rd);
    chk_bit(c < 0, 1'b1);
    xfer(18'h00400, fpm_pkg::AT_READ, 16'h0000);
    chk_data(rd, 16'h1111);
  endtask : t_abort

  // Last word in range, first word out of range, select pin alone
  task automatic t_select;
    xfer(18'h07ffe, fpm_pkg::AT_WORD_WRITE, 16'h7e81);
    xfer(18'h07ffe, fpm_pkg::AT_READ, 16'h0000);
    chk_data(rd, 16'h7e81);
    xfer(18'h08000, fpm_pkg::AT_READ, 16'h0000);
    chk_bit(mem_selected, 1'b0);
    chk_bit(c < 0, 1'b1);
    fpm_cpu_model_inst.select_only(1'b1);
    repeat (4) @(posedge clk);
    chk_bit(sec_block, 1'b1);
    fpm_cpu_model_inst.select_only(1'b0);
    repeat (4) @(posedge clk);
    chk_bit(sec_block, 1'b0);
  endtask : t_select

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    chk_data(cpu_data_in, 16'h0000);
    chk_bit(cycle_sync | mem_selected | perr | sec_block, 1'b0);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_word;
    t_slow;
    t_byte;
    t_pause;
    t_abort;
    t_select;
    end_sim;
  end

endmodule : tb_fast_processor_memory_port

`default_nettype wire
